//--- core/usio_mode0.sv
// Top of the synchronous shift-mode serial port with register port.
// Assumes a master that strobes one register access per cycle at most.
//
// What this block does, and what the external shifter and software do
// R1: Shift clock runs at oscillator divided by twelve.
// R2: Data pin bidirectional, clock pin output only.
// R3: Eight bits per transfer, least significant first.
// R4: Control write with receive enable starts reception.
// R5: Receive done flag sets, stays until cleared.
// R6: Buffer read returns last received byte.
// R7: Buffer write without receive enable transmits.
// R8: Transmit done flag stays until software clears.
// R9: External shifter loads while strobe is low.
// R10: External shifter shifts while strobe high.
// R11: Pulse load strobe low before receiving group.
// R12: Clock idles high, consistent data edges.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
module usio_mode0
  import usio_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  output logic shiftClkOut,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  output logic loadStrobe,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser.

  logic dinMeta_q; // First stage, read only by the second.
  logic dinSync_q; // Second stage, safe for logic.

  // The data pin comes from the external shifter, another domain.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dinMeta_q <= 1'b0;
      dinSync_q <= 1'b0;
    end
    else
    begin
      dinMeta_q <= serialDataIn;
      dinSync_q <= dinMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register decode.

  wire selCtl = (regAddr == USIO_OFF_CONTROL);
  wire selBuf = (regAddr == USIO_OFF_BUFFER);
  wire selAux = (regAddr == USIO_OFF_AUXCFG);
  wire selSts = (regAddr == USIO_OFF_STATUS);
  wire selMsk = (regAddr == USIO_OFF_MASK);
  wire selStb = (regAddr == USIO_OFF_STROBE);
  wire wrCtl = regWr && selCtl;
  wire wrBuf = regWr && selBuf;

  logic [7:0] ctl_q; // Serial control register.
  logic [7:0] aux_q; // Auxiliary configuration, stored only.
  logic [7:0] mask_q; // Interrupt mask.
  logic [1:0] sts_q; // Sticky interrupt status.
  logic load_q; // Load strobe pin level.
  logic [7:0] rdata_q; // Read data, valid the cycle after a read.
  logic start_q; // One-cycle start for the shifter.
  logic startRx_q; // Direction of that start.
  logic [7:0] txByte_q; // Byte held for transmission.

  // Shift mode is selected when the mode field is zero.
  wire shiftMode = (ctl_q[USIO_CTL_MODE_HI:USIO_CTL_MODE_LO]
                    == USIO_MODE_SHIFT);
  wire [7:0] ctlNew = regWdata;
  wire newShift = (ctlNew[USIO_CTL_MODE_HI:USIO_CTL_MODE_LO]
                   == USIO_MODE_SHIFT);

  wire engBusy;
  wire engDone;
  wire engClk;
  wire engOut;
  wire engOe;
  wire [7:0] engRx;

  // Reception starts on a control write selecting shift mode with
  // receive enabled. R4
  wire goRx = wrCtl && newShift && ctlNew[USIO_CTL_RXEN] && !engBusy;
  // A buffer write starts transmission when receive is disabled. R7
  wire goTx = wrBuf && shiftMode && !ctl_q[USIO_CTL_RXEN] && !engBusy;

  // Completion events by direction.
  wire rxEvt = engDone && startRx_q;
  wire txEvt = engDone && !startRx_q;

  ////////////////////////////////////////////////////////////////////////
  // Control register with hardware-set done flags.

  // Done flags set by hardware; a set in the clearing cycle wins. R5 R8
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctl_q <= USIO_RST_CONTROL;
    else
    begin
      if (wrCtl)
        ctl_q <= ctlNew;
      if (rxEvt)
        ctl_q[USIO_CTL_RXDONE] <= 1'b1; // R5
      if (txEvt)
        ctl_q[USIO_CTL_TXDONE] <= 1'b1; // R8
    end
  end

  // Start pulse and byte latch for the shift engine.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      start_q <= 1'b0;
      startRx_q <= 1'b0;
      txByte_q <= '0;
    end
    else
    begin
      start_q <= goRx || goTx;
      if (goRx || goTx)
        startRx_q <= goRx;
      if (wrBuf)
        txByte_q <= regWdata;
    end
  end

  // Plain configuration registers and the load strobe pin.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aux_q <= USIO_RST_AUXCFG;
      mask_q <= USIO_RST_MASK;
      load_q <= 1'b1;
    end
    else
    begin
      if (regWr && selAux)
        aux_q <= regWdata;
      if (regWr && selMsk)
        mask_q <= regWdata;
      // Software pulses this low then high before a receive group. R11
      if (regWr && selStb)
        load_q <= regWdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, cleared by reading it.

  // A completion that lands on the clearing read is kept.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sts_q <= '0;
    else
    begin
      if (regRd && selSts)
        sts_q <= '0;
      if (rxEvt)
        sts_q[USIO_IRQ_RX] <= 1'b1;
      if (txEvt)
        sts_q[USIO_IRQ_TX] <= 1'b1;
    end
  end

  assign irq = |(sts_q & mask_q[1:0]);

  ////////////////////////////////////////////////////////////////////////
  // Read path; unmapped addresses read as zero.

  wire [7:0] rdMux =
    selCtl ? ctl_q :
    selBuf ? engRx : // R6
    selAux ? aux_q :
    selSts ? {6'h00, sts_q} :
    selMsk ? mask_q :
    selStb ? {6'h00, engBusy, load_q} : 8'h00;

  // Data registered so it stands in exactly the cycle after the read.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= '0;
    else
      rdata_q <= regRd ? rdMux : 8'h00;
  end

  assign regRdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Shift engine at oscillator over twelve. R1

  usio_shifter #(
    .DATA_BITS(USIO_BITS),
    .HALF_DIV(USIO_HALF_DIV)
  ) u_shifter (
    .clk(clk),
    .rstn(rstn),
    .start(start_q),
    .receive(startRx_q),
    .txByte(txByte_q),
    .dataIn(dinSync_q),
    .shiftClk(engClk),
    .dataOut(engOut),
    .dataOe(engOe),
    .busy(engBusy),
    .done(engDone),
    .rxByte(engRx)
  );

  // Clock pin is output only; data pin turns around by direction. R2
  assign shiftClkOut = engClk;
  assign serialDataOut = engOut;
  assign serialDataOe = engOe;
  assign loadStrobe = load_q;

endmodule : usio_mode0

//--- core/usio_pkg.sv
// Package for the synchronous shift-mode serial port block.
// Assumes one 100 MHz clock and a plain strobe register port.
package usio_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] USIO_OFF_CONTROL = 8'h98;
  localparam logic [7:0] USIO_OFF_BUFFER = 8'h99;
  localparam logic [7:0] USIO_OFF_AUXCFG = 8'h8e;
  localparam logic [7:0] USIO_OFF_STATUS = 8'ha0;
  localparam logic [7:0] USIO_OFF_MASK = 8'ha1;
  localparam logic [7:0] USIO_OFF_STROBE = 8'ha2;

  // Reset values.
  localparam logic [7:0] USIO_RST_CONTROL = 8'h00;
  localparam logic [7:0] USIO_RST_AUXCFG = 8'h00;
  localparam logic [7:0] USIO_RST_MASK = 8'h00;

  // Field positions in the serial control register.
  localparam int USIO_CTL_TXDONE = 1;
  localparam int USIO_CTL_RXDONE = 0;
  localparam int USIO_CTL_RXEN = 4;
  localparam int USIO_CTL_MODE_HI = 7;
  localparam int USIO_CTL_MODE_LO = 6;
  localparam logic [1:0] USIO_MODE_SHIFT = 2'h0;

  // Field positions in the interrupt status and mask registers.
  localparam int USIO_IRQ_RX = 0;
  localparam int USIO_IRQ_TX = 1;

  // Shift clock timing: oscillator divided by twelve.
  localparam int USIO_SHIFT_DIV = 12;
  localparam int USIO_HALF_DIV = USIO_SHIFT_DIV / 2;
  localparam int USIO_BITS = 8;

  // Transfer states.
  typedef enum logic [1:0] {USIO_IDLE, USIO_LOW, USIO_HIGH} usio_state_type;

endpackage : usio_pkg

//--- core/usio_shifter.sv
// Shift engine: moves one byte over the data pin under a divided clock.
// Assumes a single-cycle start pulse and a synchronised data input.
`timescale 1ns/1ns
module usio_shifter
  import usio_pkg::*;
#(
  parameter int DATA_BITS = USIO_BITS,
  parameter int HALF_DIV = USIO_HALF_DIV
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic receive,
  input wire logic [DATA_BITS-1:0] txByte,
  input wire logic dataIn,
  output logic shiftClk,
  output logic dataOut,
  output logic dataOe,
  output logic busy,
  output logic done,
  output logic [DATA_BITS-1:0] rxByte
);

  // Refuse sizes the counters below cannot represent.
  if (DATA_BITS < 1 || HALF_DIV < 1)
  begin : g_badParams
    $error("usio_shifter: width and divider must be positive");
  end

  localparam int CW = $clog2(HALF_DIV + 1);
  localparam int BW = $clog2(DATA_BITS + 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(HALF_DIV - 1);
  localparam logic [BW-1:0] BIT_LAST = BW'(DATA_BITS - 1);

  usio_state_type state_q, state_d; // Phase of the shift clock.
  logic [CW-1:0] tick_q; // Cycles spent in the current half period.
  logic [BW-1:0] bit_q; // Index of the bit in flight.
  logic [DATA_BITS-1:0] sh_q; // Shift register, bit 0 goes first.
  logic rx_q; // Direction latched at start.
  logic done_q; // One-cycle completion pulse.

  wire halfEnd = (tick_q == HALF_LAST);
  wire lastBit = (bit_q == BIT_LAST);

  // Next-state logic; clock is low in LOW and high in HIGH and IDLE.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      USIO_IDLE: if (start) state_d = USIO_LOW;
      USIO_LOW: if (halfEnd) state_d = USIO_HIGH;
      USIO_HIGH: if (halfEnd) state_d = lastBit ? USIO_IDLE : USIO_LOW;
    endcase
  end

  // Sequencer; data changes on the falling edge, sampled on rising. R12
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= USIO_IDLE;
      tick_q <= '0;
      bit_q <= '0;
      sh_q <= '0;
      rx_q <= 1'b0;
      done_q <= 1'b0;
      rxByte <= '0;
    end
    else
    begin
      state_q <= state_d;
      done_q <= 1'b0;
      tick_q <= (state_q == USIO_IDLE || halfEnd) ? '0 : tick_q + 1'b1;
      if (state_q == USIO_IDLE && start)
      begin
        sh_q <= txByte;
        rx_q <= receive;
        bit_q <= '0;
      end
      // Rising edge: capture the incoming bit into the top, LSB first. R3
      if (state_q == USIO_LOW && halfEnd && rx_q)
        sh_q <= {dataIn, sh_q[DATA_BITS-1:1]};
      // Falling edge: next transmit bit, so it stands over the rise. R12
      if (state_q == USIO_HIGH && halfEnd && !rx_q)
        sh_q <= {sh_q[0], sh_q[DATA_BITS-1:1]};
      if (state_q == USIO_HIGH && halfEnd)
      begin
        bit_q <= bit_q + 1'b1;
        if (lastBit)
        begin
          done_q <= 1'b1;
          if (rx_q)
            rxByte <= sh_q;
        end
      end
    end
  end

  // Clock idles high; data pin driven only while transmitting. R2
  assign shiftClk = (state_q != USIO_LOW);
  assign dataOut = sh_q[0];
  assign dataOe = (state_q != USIO_IDLE) && !rx_q;
  assign busy = (state_q != USIO_IDLE);
  assign done = done_q;

endmodule : usio_shifter

//--- sim/usio_mode0_asserts.sv
// Checker for the shift-mode serial port top.
// Sees only the top ports; bound at the foot.
`timescale 1ns/1ns
module usio_mode0_asserts
  import usio_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic shiftClkOut,
  input wire logic serialDataIn,
  input wire logic serialDataOut,
  input wire logic serialDataOe,
  input wire logic loadStrobe,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // High cycles in a row, and bits seen in the byte.
  logic [3:0] highCnt_q;
  logic [3:0] bitCnt_q;
  // A gap longer than a half bit means a new byte.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      highCnt_q <= 4'hf;
      bitCnt_q <= 4'h0;
    end
    else
    begin
      highCnt_q <= !shiftClkOut ? 4'h0 :
        highCnt_q + {3'h0, highCnt_q != 4'hf};
      if ($fell(shiftClkOut))
        bitCnt_q <= (highCnt_q > 4'h6) ? 4'h1 : bitCnt_q + 4'h1;
    end
  end
  chk_low_half: assert property ($fell(shiftClkOut) |->
    !shiftClkOut[*6] ##1 shiftClkOut) else $error("low half");
  chk_high_half: assert property ($rose(shiftClkOut) |->
    shiftClkOut[*6]) else $error("high half");
  chk_eight_bits: assert property ($fell(shiftClkOut) &&
    highCnt_q <= 4'h6 |-> bitCnt_q < 4'h8) else $error("bits");
  chk_byte_end: assert property ($rose(shiftClkOut) &&
    bitCnt_q == 4'h8 |-> shiftClkOut[*8]) else $error("idle");
  chk_data_hold: assert property (serialDataOe &&
    $past(serialDataOe) && ($rose(shiftClkOut) || !shiftClkOut &&
    !$fell(shiftClkOut)) |-> $stable(serialDataOut))
    else $error("data moved");
  chk_oe_start: assert property ($rose(serialDataOe) |->
    $fell(shiftClkOut)) else $error("oe start");
  chk_read_idle: assert property (!$past(regRd) |->
    regRdata == 8'h00) else $error("stray data");
  chk_strobe_src: assert property ($changed(loadStrobe) |->
    $past(regWr) && $past(regAddr) == USIO_OFF_STROBE &&
    loadStrobe == $past(regWdata[0])) else $error("strobe");
  chk_irq_clear: assert property (regRd &&
    regAddr == USIO_OFF_STATUS |-> ##2 !irq) else $error("irq");
  cover property ($rose(irq));
  cover property ($fell(loadStrobe));
  cover property ($rose(shiftClkOut) && bitCnt_q == 4'h8);
endmodule : usio_mode0_asserts

bind usio_mode0 usio_mode0_asserts chk (.clk(clk), .rstn(rstn),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .shiftClkOut(shiftClkOut),
  .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
  .serialDataOe(serialDataOe), .loadStrobe(loadStrobe), .irq(irq));

//--- sim/usio_shift_model.sv
// Two cascaded load shifters feeding the pin, one capture shifter.
// Assumes shiftClk and the resolved pin level from the bench.
`timescale 1ns/1ns
module usio_shift_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic shiftClk,
  input wire logic loadStrobe,
  input wire logic pin,
  input wire logic [15:0] parIn,
  output logic serOut,
  output logic [7:0] parOut
);
  logic clkSeen_q;
  logic [15:0] inReg_q;
  // Shifting on the rise, after the port has sampled.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clkSeen_q <= 1'b1;
      inReg_q <= 16'h0000;
      parOut <= 8'h00;
    end
    else
    begin
      clkSeen_q <= shiftClk;
      if (!loadStrobe)
        inReg_q <= parIn;
      else if (shiftClk && !clkSeen_q)
        inReg_q <= {~inReg_q[0], inReg_q[15:1]};
      if (shiftClk && !clkSeen_q)
        parOut <= {pin, parOut[7:1]};
    end
  end
  assign serOut = inReg_q[0];
endmodule : usio_shift_model

//--- sim/usio_mode0_bench.sv
// Self-checking bench for the shift-mode serial port.
// Assumes the shift model and the bound checker.
`timescale 1ns/1ns
module usio_mode0_bench;
  import usio_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic shiftClkOut, serialDataOut, serialDataOe, loadStrobe, irq;
  logic modelOut, rdPend = 1'b0;
  logic [7:0] capByte, b;
  logic [15:0] parIn = 16'h0000;
  logic [31:0] rnd = 32'd89101;
  logic [7:0] expQ[$];
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  // The pin carries whichever side is driving it.
  wire pin = serialDataOe ? serialDataOut : modelOut;
  initial forever #5 clk = ~clk;
  usio_mode0 dut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .shiftClkOut(shiftClkOut),
    .serialDataIn(pin), .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe), .loadStrobe(loadStrobe), .irq(irq));
  usio_shift_model far (.clk(clk), .rstn(rstn), .shiftClk(shiftClkOut),
    .loadStrobe(loadStrobe), .pin(pin), .parIn(parIn),
    .serOut(modelOut), .parOut(capByte));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : wr
  // The expected byte is noted before the strobe goes out.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
  endtask : rd
  // Bounded wait; irq is the only completion seen at the ports.
  task automatic waitIrq;
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (irq !== 1'b1 && n < 300);
    if (n >= 300)
      chk(8'h00, 8'h01);
    @(posedge clk);
  endtask : waitIrq
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  // Read data stand one cycle after the strobe edge.
  always @(posedge clk)
  begin
    if (rdPend)
      chk(regRdata, expQ.pop_front());
    rdPend <= regRd;
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      finish_test;
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(USIO_OFF_CONTROL, USIO_RST_CONTROL);
    rd(USIO_OFF_AUXCFG, USIO_RST_AUXCFG);
    rd(USIO_OFF_MASK, USIO_RST_MASK);
    rd(USIO_OFF_STROBE, 8'h01);
    rd(8'h55, 8'h00);
    rnd = xs(rnd);
    wr(USIO_OFF_AUXCFG, rnd[7:0]);
    rd(USIO_OFF_AUXCFG, rnd[7:0]);
    $display("registers done");
    wr(USIO_OFF_MASK, 8'h03);
    // A second buffer write mid-byte must not disturb the first.
    for (int i = 0; i < 3; i++)
    begin
      rnd = xs(rnd);
      b = rnd[7:0];
      wr(USIO_OFF_BUFFER, b);
      repeat (20) @(posedge clk);
      wr(USIO_OFF_BUFFER, ~b);
      waitIrq;
      chk(capByte, b);
      rd(USIO_OFF_CONTROL, 8'h02);
      rd(USIO_OFF_STATUS, 8'h02);
      wr(USIO_OFF_CONTROL, 8'h00);
      rd(USIO_OFF_CONTROL, 8'h00);
    end
    $display("transmit done");
    rnd = xs(rnd);
    parIn <= rnd[15:0];
    wr(USIO_OFF_STROBE, 8'h00);
    rd(USIO_OFF_STROBE, 8'h00);
    wr(USIO_OFF_STROBE, 8'h01);
    for (int i = 0; i < 2; i++)
    begin
      wr(USIO_OFF_CONTROL, 8'h10);
      waitIrq;
      rd(USIO_OFF_STATUS, 8'h01);
      rd(USIO_OFF_CONTROL, 8'h11);
      rd(USIO_OFF_BUFFER, parIn[8*i+:8]);
      wr(USIO_OFF_CONTROL, 8'h00);
    end
    wr(USIO_OFF_MASK, 8'h00);
    wr(USIO_OFF_CONTROL, 8'h10);
    repeat (120) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    rd(USIO_OFF_STATUS, 8'h01);
    $display("receive done");
    finish_test;
  end
endmodule : usio_mode0_bench
